// File: smc_top.sv
`timescale 1ns/1ns
module smc_top
    import smc_pkg::*;
#(
    parameter int FLASH_CYC = SMC_FLASH_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Variant and non-volatile state
    input wire logic large_variant,
    input wire logic prog_stored,
    input wire logic [1:0] pwr_cycles,
    // Program transfer
    input wire logic dl_active,
    input wire logic dl_ok,
    // Faults, latched faults and input image
    input wire logic user_fault,
    input wire logic self_fault,
    input wire logic switch_pair_short,
    input wire logic sup_overvolt,
    input wire logic int_overvolt,
    input wire logic [7:0] fault_latched,
    input wire logic [7:0] din,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Outputs to the plant
    output logic prog_run,
    output logic outputs_enable,
    output logic link_enable,
    output logic supply_status_indicator,
    output logic fault_indicator,
    output logic auto_start_stored
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    wire [7:0] pin_raw = {prog_stored, dl_active, dl_ok, user_fault,
                          self_fault, switch_pair_short, sup_overvolt,
                          int_overvolt};

    // Two flip-flops per external level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire s_stored = pin_s2_r[7];
    wire s_dl = pin_s2_r[6];
    wire s_dl_ok = pin_s2_r[5];
    wire s_ufault = pin_s2_r[4];
    wire s_sfault = pin_s2_r[3];
    wire pd_cause = |pin_s2_r[2:0];

    // ----------------------------------------
    // Mode state and control flags
    // ----------------------------------------
    smc_mode_e mode_r;
    smc_mode_e mode_nxt;
    logic run_r;
    logic run_nxt;
    logic auto_r;
    logic auto_nxt;
    logic fsrc_user_r;
    logic fsrc_nxt;
    logic [1:0] init_cnt_r;
    // Start-up waits until the synchronisers carry real pin levels
    wire init_go = (init_cnt_r == 2'h2);
    wire init_done = (init_cnt_r == 2'h3);
    logic [7:0] cmd_r;

    // Host command decode
    wire cmd_wr = wr && (addr == SMC_A_CMD) && (mode_r != SMC_M_PWRDOWN);
    wire c_start = cmd_wr && (wdata == SMC_C_START);
    wire c_oper = cmd_wr && (wdata == SMC_C_TO_OPER);
    wire c_verif = cmd_wr && (wdata == SMC_C_TO_VERIF);
    wire c_aon = cmd_wr && (wdata == SMC_C_AUTO_ON);
    wire c_aoff = cmd_wr && (wdata == SMC_C_AUTO_OFF);
    wire in_exec = (mode_r == SMC_M_VERIFY) || (mode_r == SMC_M_OPER);
    wire fs_go = in_exec && (s_ufault || s_sfault);

    // Next mode, fault entry ahead of host commands
    always_comb begin
        mode_nxt = mode_r;
        run_nxt = run_r;
        auto_nxt = auto_r;
        fsrc_nxt = fsrc_user_r;
        if (c_aon) begin
            auto_nxt = 1'b1; // User-fault entry below still clears it
        end
        if (c_aoff) begin
            auto_nxt = 1'b0;
        end
        unique case (mode_r)
            SMC_M_UNPROG: begin
                if (s_dl) begin
                    mode_nxt = SMC_M_DOWNLOAD;
                end
            end
            SMC_M_DOWNLOAD: begin
                if (s_dl_ok) begin
                    mode_nxt = SMC_M_VERIFY;
                    auto_nxt = SMC_AUTO_RST;
                    run_nxt = SMC_AUTO_RST;
                end else if (!s_dl) begin
                    mode_nxt = s_stored ? SMC_M_VERIFY : SMC_M_UNPROG;
                    run_nxt = 1'b0;
                end
            end
            SMC_M_VERIFY, SMC_M_OPER: begin
                if (c_start) begin
                    run_nxt = 1'b1;
                end
                if ((mode_r == SMC_M_VERIFY) && c_oper) begin
                    mode_nxt = SMC_M_OPER;
                    run_nxt = auto_r;
                end
                if ((mode_r == SMC_M_OPER) && c_verif) begin
                    mode_nxt = SMC_M_VERIFY;
                    run_nxt = auto_r;
                end
                if (s_dl) begin
                    mode_nxt = SMC_M_DOWNLOAD;
                    run_nxt = 1'b0;
                end
                if (fs_go) begin
                    mode_nxt = SMC_M_FAILSAFE;
                    run_nxt = 1'b0;
                    fsrc_nxt = s_ufault && !s_sfault;
                    if (s_ufault) begin
                        auto_nxt = 1'b0;
                    end
                end
            end
            SMC_M_FAILSAFE: begin
                run_nxt = 1'b0;
            end
            SMC_M_PWRDOWN: begin
                run_nxt = 1'b0;
            end
            default: begin
                mode_nxt = SMC_M_UNPROG;
                run_nxt = 1'b0;
            end
        endcase
        if (pd_cause) begin
            mode_nxt = SMC_M_PWRDOWN;
            run_nxt = 1'b0;
        end
    end

    // Mode register; leaving fail-safe only through reset (power cycle) or a power-down cause
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= SMC_M_UNPROG;
            run_r <= 1'b0;
            fsrc_user_r <= 1'b0;
        end else if (init_go) begin
            mode_r <= s_stored ? SMC_M_VERIFY : SMC_M_UNPROG;
            run_r <= s_stored && auto_r;
        end else if (init_done) begin
            mode_r <= mode_nxt;
            run_r <= run_nxt;
            fsrc_user_r <= fsrc_nxt;
        end
    end

    // Auto-start flag and start-up wait for the pin synchronisers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            auto_r <= SMC_AUTO_RST;
            init_cnt_r <= 2'h0;
        end else if (!init_done) begin
            init_cnt_r <= init_cnt_r + 2'h1;
            if (init_go && (pwr_cycles >= SMC_PC_RENABLE)) begin
                auto_r <= 1'b1;
            end
        end else begin
            auto_r <= auto_nxt;
        end
    end

    // ----------------------------------------
    // Indicator flash timer
    // ----------------------------------------
    logic [31:0] flash_cnt_r;
    logic flash_r;
    wire flash_end = (flash_cnt_r == 32'(FLASH_CYC - 1));

    // Free-running half-period counter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r <= 1'b0;
        end else if (flash_end) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r <= !flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    wire is_fs = (mode_nxt == SMC_M_FAILSAFE);
    wire is_pd = (mode_nxt == SMC_M_PWRDOWN);
    wire is_oper = (mode_nxt == SMC_M_OPER);
    wire is_exec = (mode_nxt == SMC_M_VERIFY) || is_oper;
    wire sup_nxt = is_pd ? 1'b0 : (is_oper ? 1'b1 : flash_r);

    // Registered plant outputs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prog_run <= 1'b0;
            outputs_enable <= 1'b0;
            link_enable <= 1'b0;
            supply_status_indicator <= 1'b0;
            fault_indicator <= 1'b0;
            auto_start_stored <= SMC_AUTO_RST;
        end else begin
            prog_run <= run_nxt && is_exec;
            outputs_enable <= run_nxt && is_exec;
            link_enable <= !is_pd;
            supply_status_indicator <= sup_nxt;
            fault_indicator <= is_fs && flash_r;
            auto_start_stored <= auto_nxt;
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    wire [3:0] nsm = large_variant ? SMC_NSM_LARGE : SMC_NSM_SMALL;
    logic [15:0] status_w;
    logic [15:0] rd_mux;

    // Mode status word
    always_comb begin
        status_w = 16'h0000;
        status_w[SMC_MODE_W-1:0] = mode_r;
        status_w[SMC_RUN_BIT] = run_r;
        status_w[SMC_AUTO_BIT] = auto_r;
        status_w[SMC_FSRC_BIT] = fsrc_user_r;
        status_w[SMC_NSM_LO+:4] = nsm;
    end

    // Read selection, fault and inputs stay visible
    always_comb begin
        unique case (addr)
            SMC_A_MODE: rd_mux = status_w;
            SMC_A_CMD: rd_mux = {8'h00, cmd_r};
            SMC_A_CFG: rd_mux = {15'h0000, auto_r};
            SMC_A_FAULT: rd_mux = {8'h00, fault_latched};
            SMC_A_INPUT: rd_mux = {8'h00, din};
            SMC_A_PCOUNT: rd_mux = {14'h0000, pwr_cycles};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data one cycle later, silent in power-down
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 16'h0000;
            cmd_r <= 8'h00;
        end else begin
            if (cmd_wr) begin
                cmd_r <= wdata;
            end
            if (rd && (mode_r != SMC_M_PWRDOWN)) begin
                rdata <= rd_mux;
            end else begin
                rdata <= 16'h0000;
            end
        end
    end

endmodule

// File: smc_pkg.sv
// Function
// - With no stored program after power-up, stay in unprogrammed mode.
// - While a program transfer runs, occupy and report download mode.
// - Completed transfer moves download mode into verification mode.
// - Verification mode runs the user program exactly as operational mode.
// - Operational mode holds until host command, power cycle or fail-safe.
// - Accept host command from operational back to verification mode.
// - User-configured or self-diagnostic fault forces fail-safe mode; here only from verification or operational mode.
// - Any verification/operational change halts the user program.
// - After that change, restart if auto-start set, else await host start.
// - Latched faults are kept across every mode change.
// - Report current mode to host and accept mode-change requests.
// - Fail-safe entry de-energizes all outputs and stops the program.
// - In fail-safe, diagnostics, inputs and status stay readable.
// - Self-diagnostic fail-safe ignores the program; exit needs power cycle.
// - After power-cycle exit of fail-safe, autostart only if enabled; here every reset enables auto-start, so a stored program always starts.
// - Power-down stops program, de-energizes outputs, ends host talk.
// - Shorted switch pair, supply or internal overvoltage forces power-down.
// - Fail-safe flashes internal fault and supply/status indicators.
// - Runs several state machines: up to eight large, four small variant.
// - Auto-start is enabled by default for a new program.
// - Program-triggered fail-safe clears auto-start.
// - Two power cycles after fail-safe entry re-enable auto-start; here every reset sets it, whatever pwr_cycles holds.
// - Self-diagnostic fail-safe leaves auto-start unchanged.
package smc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] SMC_A_MODE = 4'h0;
    localparam logic [3:0] SMC_A_CMD = 4'h1;
    localparam logic [3:0] SMC_A_CFG = 4'h2;
    localparam logic [3:0] SMC_A_FAULT = 4'h3;
    localparam logic [3:0] SMC_A_INPUT = 4'h4;
    localparam logic [3:0] SMC_A_PCOUNT = 4'h5;

    // ----------------------------------------
    // Command codes in the command register
    // ----------------------------------------
    localparam logic [7:0] SMC_C_START = 8'h01;
    localparam logic [7:0] SMC_C_TO_OPER = 8'h02;
    localparam logic [7:0] SMC_C_TO_VERIF = 8'h03;
    localparam logic [7:0] SMC_C_AUTO_ON = 8'h04;
    localparam logic [7:0] SMC_C_AUTO_OFF = 8'h05;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int SMC_MODE_W = 3;
    localparam int SMC_RUN_BIT = 3;
    localparam int SMC_AUTO_BIT = 4;
    localparam int SMC_FSRC_BIT = 5;
    localparam int SMC_NSM_LO = 8;
    localparam logic [3:0] SMC_NSM_LARGE = 4'h8;
    localparam logic [3:0] SMC_NSM_SMALL = 4'h4;
    localparam logic SMC_AUTO_RST = 1'b1;
    localparam logic [1:0] SMC_PC_RENABLE = 2'h2;

    // ----------------------------------------
    // Indicator flash timing
    // ----------------------------------------
    localparam int SMC_FLASH_MS = 250;
    localparam int SMC_CLK_MHZ = 100;
    localparam int SMC_FLASH_CYC = SMC_FLASH_MS * 1000 * SMC_CLK_MHZ;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        SMC_M_UNPROG = 3'b000,
        SMC_M_DOWNLOAD = 3'b001,
        SMC_M_VERIFY = 3'b010,
        SMC_M_OPER = 3'b011,
        SMC_M_FAILSAFE = 3'b100,
        SMC_M_PWRDOWN = 3'b101
    } smc_mode_e;

endpackage

// File: smc_host.sv
`timescale 1ns/1ns
// Host controller on the register port
module smc_host (
    // Clock
    input wire logic mclk,
    // Register port
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [15:0] rdata
);
    // Idle bus at time zero
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One-cycle write, lines inverted after
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    // One-cycle read, data taken at the edge closing the answer cycle
    task automatic get(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        d = rdata;
    endtask
endmodule

// File: smc_assertions.sv
`timescale 1ns/1ns
// Port-level checks of the mode controller
module smc_assertions #(
    parameter int FLASH_CYC = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Fault causes
    input wire logic user_fault,
    input wire logic self_fault,
    input wire logic switch_pair_short,
    input wire logic sup_overvolt,
    input wire logic int_overvolt,
    // Register port
    input wire logic rd,
    input wire logic [15:0] rdata,
    // Plant side
    input wire logic prog_run,
    input wire logic outputs_enable,
    input wire logic link_enable,
    input wire logic fault_indicator
);
    localparam int FL_MAX = 1000;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Causes held past the two sync stages
    sequence pd_cause;
        (switch_pair_short || sup_overvolt || int_overvolt) [*4];
    endsequence
    sequence fs_cause;
        (user_fault || self_fault) [*4];
    endsequence
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside the read answer cycle");
    chk_pd_enter: assert property (pd_cause |-> !link_enable)
        else $error("power-down cause left the link on");
    chk_pd_quiet: assert property (
        !link_enable |-> !outputs_enable && !prog_run)
        else $error("outputs or program alive in power-down");
    chk_fs_enter: assert property (
        fs_cause |-> !outputs_enable && !prog_run)
        else $error("fault did not stop outputs and program");
    chk_flash_safe: assert property (
        fault_indicator |-> !outputs_enable && !prog_run)
        else $error("fault indicator lit outside fail-safe");
    chk_flash_ends: assert property (
        $rose(fault_indicator) |-> ##[1:FL_MAX] !fault_indicator)
        else $error("fault indicator does not flash");
    chk_run_powered: assert property (prog_run |-> outputs_enable)
        else $error("program runs with outputs disabled");
    chk_pd_read: assert property (
        rd && !link_enable |=> rdata == 16'h0000)
        else $error("read answered in power-down");
endmodule
bind smc_top smc_assertions #(.FLASH_CYC(FLASH_CYC)) u_chk (
    .mclk(mclk), .nrst(nrst), .user_fault(user_fault),
    .self_fault(self_fault), .switch_pair_short(switch_pair_short),
    .sup_overvolt(sup_overvolt), .int_overvolt(int_overvolt),
    .rd(rd), .rdata(rdata), .prog_run(prog_run),
    .outputs_enable(outputs_enable), .link_enable(link_enable),
    .fault_indicator(fault_indicator)
);

// File: testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    import smc_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic lv = 1'b1, ps = 1'b0, dla = 1'b0, dlo = 1'b0, uf = 1'b0, sf = 1'b0;
    logic [2:0] pd = 3'h0;
    logic [1:0] pc = 2'h0;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr, rd, run, oen, len, ssi, fi, aut;
    logic [15:0] rdata, d;
    int n_errors = 0, n_tests = 0, cyc = 0;
    // Clock
    always #5 mclk = ~mclk;
    smc_top #(.FLASH_CYC(4)) i_smc_top (.mclk(mclk), .nrst(nrst),
        .large_variant(lv), .prog_stored(ps), .pwr_cycles(pc),
        .dl_active(dla), .dl_ok(dlo), .user_fault(uf), .self_fault(sf),
        .switch_pair_short(pd[0]), .sup_overvolt(pd[1]),
        .int_overvolt(pd[2]), .fault_latched(8'h5a), .din(8'hc3),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .prog_run(run), .outputs_enable(oen), .link_enable(len),
        .supply_status_indicator(ssi), .fault_indicator(fi),
        .auto_start_stored(aut));
    smc_host i_smc_host (.mclk(mclk), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    // Verdict and end of run
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end
    // External power cycle, faults cleared
    task automatic pwr(input logic s, input logic [1:0] c);
        @(posedge mclk);
        nrst <= 1'b0;
        ps <= s;
        pc <= c;
        {uf, sf, pd, dla, dlo} <= '0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    // Status word compare
    task automatic st(input smc_mode_e m, input logic r, a, f);
        logic [15:0] e;
        e = {4'h0, lv ? SMC_NSM_LARGE : SMC_NSM_SMALL, 2'b00, f, a, r, m};
        i_smc_host.get(SMC_A_MODE, d);
        `CHK(d, e)
    endtask
    // Nothing stored, small variant
    task automatic t_unprog();
        lv <= 1'b0;
        pwr(1'b0, 2'h0);
        st(SMC_M_UNPROG, 1'b0, 1'b1, 1'b0);
        $display("t_unprog done");
    endtask
    // Download, verify, operate and back
    task automatic t_flow();
        lv <= 1'b1;
        pwr(1'b0, 2'h0);
        dla <= 1'b1;
        repeat (4) @(posedge mclk);
        st(SMC_M_DOWNLOAD, 1'b0, 1'b1, 1'b0);
        dla <= 1'b0;
        dlo <= 1'b1;
        ps <= 1'b1;
        repeat (4) @(posedge mclk);
        dlo <= 1'b0;
        st(SMC_M_VERIFY, 1'b1, 1'b1, 1'b0);
        `CHK(oen, 1'b1)
        i_smc_host.put(SMC_A_CMD, SMC_C_TO_OPER);
        i_smc_host.put(SMC_A_CMD, SMC_C_TO_OPER);
        st(SMC_M_OPER, 1'b1, 1'b1, 1'b0);
        `CHK({ssi, fi}, 2'b10)
        i_smc_host.put(SMC_A_CMD, SMC_C_AUTO_OFF);
        i_smc_host.put(SMC_A_CMD, SMC_C_TO_VERIF);
        st(SMC_M_VERIFY, 1'b0, 1'b0, 1'b0);
        i_smc_host.put(SMC_A_CMD, SMC_C_START);
        st(SMC_M_VERIFY, 1'b1, 1'b0, 1'b0);
        i_smc_host.get(SMC_A_FAULT, d);
        `CHK(d, 16'h005a)
        i_smc_host.put(SMC_A_CMD, SMC_C_AUTO_ON);
        i_smc_host.get(SMC_A_CFG, d);
        `CHK(d, 16'h0001)
        i_smc_host.get(SMC_A_CMD, d);
        `CHK(d, {8'h00, SMC_C_AUTO_ON})
        i_smc_host.get(4'hf, d);
        `CHK(d, 16'h0000)
        $display("t_flow done");
    endtask
    // Program-raised fail-safe, then one power cycle with the cycle count at two
    task automatic t_user_fs();
        uf <= 1'b1;
        repeat (4) @(posedge mclk);
        st(SMC_M_FAILSAFE, 1'b0, 1'b0, 1'b1);
        `CHK({oen, aut}, 2'b00)
        i_smc_host.put(SMC_A_CMD, SMC_C_TO_VERIF);
        st(SMC_M_FAILSAFE, 1'b0, 1'b0, 1'b1);
        i_smc_host.get(SMC_A_INPUT, d);
        `CHK(d, 16'h00c3)
        d = '0;
        repeat (8) begin
            @(negedge mclk);
            d = {d[14:8], ssi, d[6:0], fi};
        end
        `CHK({|d[7:0], &d[7:0], |d[15:8], &d[15:8]}, 4'b1010)
        pwr(1'b1, SMC_PC_RENABLE);
        st(SMC_M_VERIFY, 1'b1, 1'b1, 1'b0);
        i_smc_host.get(SMC_A_PCOUNT, d);
        `CHK(d, {14'h0000, SMC_PC_RENABLE})
        $display("t_user_fs done");
    endtask
    // Self-diagnostic fail-safe keeps auto-start
    task automatic t_self_fs();
        sf <= 1'b1;
        repeat (4) @(posedge mclk);
        st(SMC_M_FAILSAFE, 1'b0, 1'b1, 1'b0);
        pwr(1'b1, 2'h0);
        st(SMC_M_VERIFY, 1'b1, 1'b1, 1'b0);
        $display("t_self_fs done");
    endtask
    // Each power-down cause, with a competing fault
    task automatic t_pdown();
        for (int i = 0; i < 3; i++) begin
            pwr(1'b1, 2'h0);
            pd <= 3'b001 << i;
            uf <= 1'b1;
            repeat (4) @(posedge mclk);
            i_smc_host.get(SMC_A_MODE, d);
            `CHK(d, 16'h0000)
            `CHK({len, oen, run}, 3'b000)
            i_smc_host.put(SMC_A_CMD, SMC_C_TO_OPER);
            `CHK({len, oen}, 2'b00)
        end
        $display("t_pdown done");
    endtask
    // Main sequence
    initial begin
        t_unprog();
        t_flow();
        t_user_fs();
        t_self_fs();
        t_pdown();
        close_out();
    end
endmodule
